/* shared/eeprom_link_map.svh */
// constants for the two-wire serial memory link
// assumes a 10 MHz system clock on both ends
`ifndef EEPROM_LINK_MAP_SVH
`define EEPROM_LINK_MAP_SVH
`define EE_CLK_HZ 10000000
`define EE_SCL_HZ 100000
// quarter of an scl period, rounded up so scl never exceeds its top rate
`define EE_SCL_QTR ((`EE_CLK_HZ + 4 * `EE_SCL_HZ - 1) / (4 * `EE_SCL_HZ))
`define EE_TWR_MS 10
// longest internal write time, rounded down to whole cycles
`define EE_TWR_CYC (`EE_TWR_MS * (`EE_CLK_HZ / 1000))
// device type identifier; value is arbitrary
`define EE_TYPE_ID 4'h5
`define EE_ADDR_BITS 11
`define EE_PAGE_POS 4
`define EE_BYTE_END 4'h8
`define EE_RD_BIT 1'h1
`endif

/* shared/eeprom_link_pkg.sv */
// types shared by both ends of the two-wire memory link
// assumes eeprom_link_map.svh holds the numeric constants
package eeprom_link_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_rx = 3'b001,
    st_ack = 3'b010,
    st_tx = 3'b011,
    st_rxack = 3'b100,
    st_ignore = 3'b101
  } dev_state_t;
  typedef enum logic [1:0] {
    rk_dev = 2'b00,
    rk_word = 2'b01,
    rk_data = 2'b10
  } rx_kind_t;
  typedef enum logic [2:0] {
    ms_idle = 3'b000,
    ms_start = 3'b001,
    ms_tx = 3'b010,
    ms_rx = 3'b011,
    ms_stop = 3'b100
  } mst_state_t;
  typedef enum logic [2:0] {
    sq_dev = 3'b000,
    sq_word = 3'b001,
    sq_data = 3'b010,
    sq_devrd = 3'b011,
    sq_read = 3'b100
  } seq_t;
  typedef enum logic [1:0] {
    op_write = 2'b00,
    op_read_cur = 2'b01,
    op_read_rand = 2'b10,
    op_poll = 2'b11
  } op_t;
endpackage

/* shared/two_wire_if.sv */
// two-wire bus between the memory end and the bus master end
// assumes a pull-up on sda; only the master drives scl
`timescale 1ns/10ps
interface two_wire_if;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_mst_o;
  logic sda_mst_oe;
  wire sda;
  // wired-and with pull-up: any enabled low driver wins
  assign sda = ((sda_dev_oe & ~sda_dev_o) | (sda_mst_oe & ~sda_mst_o)) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport master (output scl, output sda_mst_o, output sda_mst_oe, input sda);
endinterface

/* design/eeprom_slave.sv */
// two-wire serial memory end: 2048 bytes, page write, sequential read
// assumes scl and sda arrive asynchronously and a master drives scl
`timescale 1ns/10ps
`include "eeprom_link_map.svh"
module eeprom_slave #(
  parameter int TWR_CYCLES = `EE_TWR_CYC,
  parameter logic [3:0] TYPE_ID = `EE_TYPE_ID
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  two_wire_if.device bus, // serial link
  output logic standby, // idle power state after stop
  output logic write_busy // internal write cycle running
);
  localparam int BW = $clog2(TWR_CYCLES + 1);
  localparam int AW = `EE_ADDR_BITS;
  localparam int PP = `EE_PAGE_POS;

  eeprom_link_pkg::dev_state_t state, next_state;
  eeprom_link_pkg::rx_kind_t kind, next_kind;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [3:0] bit_cnt, next_cnt;
  logic [7:0] shreg, next_sh;
  logic [AW-1:0] addr, next_addr;
  logic rw, next_rw;
  logic mack, next_mack;
  logic wrote, next_wrote;
  logic next_oe;
  logic mem_we;
  logic [BW-1:0] busy_cnt;
  logic [7:0] mem [0:(1 << AW)-1];

  // edges seen only on the second and third sync stages
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire busy = (busy_cnt != '0);
  wire byte_done = scl_fall & (bit_cnt == `EE_BYTE_END);
  wire id_match = (shreg[7:4] == TYPE_ID);
  wire [7:0] rd_byte = mem[addr];
  wire [AW-1:0] addr_seq = addr + 11'h001;
  wire [AW-1:0] addr_page = {addr[AW-1:PP], addr[PP-1:0] + 4'h1};

  // pins cross into clk_sys through three flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {bus.scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {bus.sda, sda_m, sda_s};
    end
  end

  // protocol engine; sda only moves on an scl fall
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_cnt = bit_cnt;
    next_sh = shreg;
    next_addr = addr;
    next_rw = rw;
    next_mack = mack;
    next_wrote = wrote;
    next_oe = bus.sda_dev_oe;
    mem_we = 1'b0;
    if (stop_det) begin
      next_state = eeprom_link_pkg::st_idle;
      next_oe = 1'b0;
    end else if (start_det) begin
      next_state = eeprom_link_pkg::st_rx;
      next_kind = eeprom_link_pkg::rk_dev;
      next_cnt = 4'h0;
      next_wrote = 1'b0;
      next_oe = 1'b0;
    end else begin
      case (state)
        eeprom_link_pkg::st_rx: begin
          if (scl_rise) begin
            next_sh = {shreg[6:0], sda_s};
            next_cnt = bit_cnt + 4'h1;
          end else if (byte_done) begin
            next_state = eeprom_link_pkg::st_ack;
            next_oe = 1'b1;
            case (kind)
              eeprom_link_pkg::rk_dev: begin
                // busy or foreign identifier: stay silent
                if (!id_match || busy) begin
                  next_state = eeprom_link_pkg::st_ignore;
                  next_oe = 1'b0;
                end else begin
                  next_rw = shreg[0];
                  if (!shreg[0]) begin
                    next_addr[AW-1:AW-3] = shreg[3:1];
                  end
                end
              end
              eeprom_link_pkg::rk_word: begin
                next_addr[7:0] = shreg;
              end
              default: begin
                mem_we = 1'b1;
                next_wrote = 1'b1;
                next_addr = addr_page;
              end
            endcase
          end
        end
        eeprom_link_pkg::st_ack: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_state = eeprom_link_pkg::st_tx;
              next_sh = rd_byte;
              next_oe = ~rd_byte[7];
              next_addr = addr_seq;
            end else begin
              next_state = eeprom_link_pkg::st_rx;
              next_oe = 1'b0;
              next_kind = (kind == eeprom_link_pkg::rk_dev) ? eeprom_link_pkg::rk_word
                                                           : eeprom_link_pkg::rk_data;
            end
          end
        end
        eeprom_link_pkg::st_tx: begin
          if (scl_rise) begin
            next_cnt = bit_cnt + 4'h1;
          end else if (byte_done) begin
            next_state = eeprom_link_pkg::st_rxack;
            next_oe = 1'b0;
          end else if (scl_fall) begin
            next_sh = {shreg[6:0], 1'b0};
            next_oe = ~shreg[6];
          end
        end
        eeprom_link_pkg::st_rxack: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end else if (scl_fall) begin
            next_cnt = 4'h0;
            if (mack) begin
              next_state = eeprom_link_pkg::st_tx;
              next_sh = rd_byte;
              next_oe = ~rd_byte[7];
              next_addr = addr_seq;
            end else begin
              next_state = eeprom_link_pkg::st_ignore;
            end
          end
        end
        eeprom_link_pkg::st_idle, eeprom_link_pkg::st_ignore: begin
          next_oe = 1'b0;
        end
        default: begin
          next_state = eeprom_link_pkg::st_idle;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // control state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= eeprom_link_pkg::st_idle;
      kind <= eeprom_link_pkg::rk_dev;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      addr <= '0;
      rw <= 1'b0;
      mack <= 1'b0;
      wrote <= 1'b0;
      bus.sda_dev_oe <= 1'b0;
      bus.sda_dev_o <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      bit_cnt <= next_cnt;
      shreg <= next_sh;
      addr <= next_addr;
      rw <= next_rw;
      mack <= next_mack;
      wrote <= next_wrote & ~stop_det;
      bus.sda_dev_oe <= next_oe;
      bus.sda_dev_o <= 1'b0;
    end
  end

  // self-timed write: a stop after written data arms the countdown
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= '0;
      write_busy <= 1'b0;
    end else begin
      if (stop_det && wrote && !busy) begin
        busy_cnt <= BW'(TWR_CYCLES);
      end else if (busy) begin
        busy_cnt <= busy_cnt - BW'(1);
      end
      write_busy <= (stop_det && wrote) || (busy_cnt > BW'(1));
    end
  end

  // standby follows stop, left again by any start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      standby <= 1'b1;
    end else if (stop_det) begin
      standby <= 1'b1;
    end else if (start_det) begin
      standby <= 1'b0;
    end
  end

  // array written directly; flops hold the data, no reset needed
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[addr] <= shreg;
    end
  end
endmodule // eeprom_slave

/* design/eeprom_master.sv */
// bus master end: makes scl by division and runs whole transfers
// assumes the memory end sits on the same two_wire_if
`timescale 1ns/10ps
`include "eeprom_link_map.svh"
module eeprom_master #(
  parameter int QTR = `EE_SCL_QTR,
  parameter logic [3:0] TYPE_ID = `EE_TYPE_ID
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  two_wire_if.master bus, // serial link
  input wire logic cmd_valid, // command offered
  output logic cmd_ready, // idle, command taken
  input wire eeprom_link_pkg::op_t cmd_op, // transfer kind
  input wire logic [10:0] cmd_addr, // memory address
  input wire logic [7:0] cmd_count, // byte count, at least one
  input wire logic [7:0] wr_data, // next byte to write
  output logic wr_take, // pulse: wr_data consumed
  output logic [7:0] rd_data, // byte read
  output logic rd_valid, // pulse: rd_data new
  output logic done, // pulse: stop sent
  output logic nack // no acknowledge seen
);
  localparam int QW = $clog2(QTR + 1);

  eeprom_link_pkg::mst_state_t mstate, next_ms;
  eeprom_link_pkg::seq_t seq, next_seq;
  eeprom_link_pkg::op_t op, next_op;
  logic [QW-1:0] qcnt;
  logic [1:0] q, next_q;
  logic [3:0] bit_idx, next_bit;
  logic [7:0] tx, next_tx, rx, next_rx, remain, next_remain;
  logic [10:0] addr, next_addr;
  logic got, next_got, next_oe, next_scl, next_take, next_valid, next_done, next_nack;
  logic sda_m, sda_s;

  // address byte: identifier, page bits, direction
  function automatic logic [7:0] dev_byte(input logic [2:0] page, input logic rd);
    dev_byte = {TYPE_ID, page, rd};
  endfunction

  wire tick = (qcnt == QW'(QTR - 1));
  wire last_bit = (bit_idx == `EE_BYTE_END);
  wire last_byte = (remain == 8'h01);

  // sequencing per quarter scl period
  always_comb begin
    next_ms = mstate;
    next_seq = seq;
    next_op = op;
    next_q = q;
    next_bit = bit_idx;
    next_tx = tx;
    next_rx = rx;
    next_remain = remain;
    next_addr = addr;
    next_got = got;
    next_oe = bus.sda_mst_oe;
    next_scl = bus.scl;
    next_take = 1'b0;
    next_valid = 1'b0;
    next_done = 1'b0;
    next_nack = nack;
    if (mstate == eeprom_link_pkg::ms_idle) begin
      if (cmd_valid && cmd_ready) begin
        next_ms = eeprom_link_pkg::ms_start;
        next_seq = eeprom_link_pkg::sq_dev;
        next_op = cmd_op;
        next_addr = cmd_addr;
        next_remain = cmd_count;
        next_nack = 1'b0;
        next_q = 2'h0;
      end
    end else if (tick) begin
      next_q = q + 2'h1;
      case (mstate)
        eeprom_link_pkg::ms_start: begin
          case (q)
            2'h0: next_oe = 1'b0;
            2'h1: next_scl = 1'b1;
            2'h2: next_oe = 1'b1;
            default: begin
              next_scl = 1'b0;
              next_ms = eeprom_link_pkg::ms_tx;
              next_bit = 4'h0;
              next_tx = dev_byte(addr[10:8], (seq == eeprom_link_pkg::sq_devrd) ||
                                 (op == eeprom_link_pkg::op_read_cur));
            end
          endcase
        end
        eeprom_link_pkg::ms_tx: begin
          case (q)
            2'h0: next_oe = last_bit ? 1'b0 : ~tx[7];
            2'h1: next_scl = 1'b1;
            2'h2: next_got = last_bit ? ~sda_s : got;
            default: begin
              next_scl = 1'b0;
              next_bit = bit_idx + 4'h1;
              next_tx = {tx[6:0], 1'b0};
              if (last_bit) begin
                next_bit = 4'h0;
                next_ms = eeprom_link_pkg::ms_tx;
                if (!got) begin
                  next_ms = eeprom_link_pkg::ms_stop;
                  next_nack = 1'b1;
                end else begin
                  case (seq)
                    eeprom_link_pkg::sq_dev: begin
                      if (op == eeprom_link_pkg::op_poll) begin
                        next_ms = eeprom_link_pkg::ms_stop;
                      end else if (op == eeprom_link_pkg::op_read_cur) begin
                        next_ms = eeprom_link_pkg::ms_rx;
                        next_seq = eeprom_link_pkg::sq_read;
                      end else begin
                        next_tx = addr[7:0];
                        next_seq = eeprom_link_pkg::sq_word;
                      end
                    end
                    eeprom_link_pkg::sq_word: begin
                      if (op == eeprom_link_pkg::op_read_rand) begin
                        next_ms = eeprom_link_pkg::ms_start;
                        next_seq = eeprom_link_pkg::sq_devrd;
                      end else begin
                        next_tx = wr_data;
                        next_take = 1'b1;
                        next_seq = eeprom_link_pkg::sq_data;
                      end
                    end
                    eeprom_link_pkg::sq_data: begin
                      if (last_byte) begin
                        next_ms = eeprom_link_pkg::ms_stop;
                      end else begin
                        next_remain = remain - 8'h01;
                        next_tx = wr_data;
                        next_take = 1'b1;
                      end
                    end
                    eeprom_link_pkg::sq_devrd: begin
                      next_ms = eeprom_link_pkg::ms_rx;
                      next_seq = eeprom_link_pkg::sq_read;
                    end
                    default: next_ms = eeprom_link_pkg::ms_stop;
                  endcase
                end
              end
            end
          endcase
        end
        eeprom_link_pkg::ms_rx: begin
          case (q)
            2'h0: next_oe = last_bit ? ~last_byte : 1'b0;
            2'h1: next_scl = 1'b1;
            2'h2: next_rx = last_bit ? rx : {rx[6:0], sda_s};
            default: begin
              next_scl = 1'b0;
              next_bit = bit_idx + 4'h1;
              next_valid = (bit_idx == 4'h7);
              if (last_bit) begin
                next_bit = 4'h0;
                if (last_byte) begin
                  next_ms = eeprom_link_pkg::ms_stop;
                end else begin
                  next_remain = remain - 8'h01;
                end
              end
            end
          endcase
        end
        eeprom_link_pkg::ms_stop: begin
          case (q)
            2'h0: next_oe = 1'b1;
            2'h1: next_scl = 1'b1;
            2'h2: next_oe = 1'b0;
            default: begin
              next_ms = eeprom_link_pkg::ms_idle;
              next_done = 1'b1;
            end
          endcase
        end
        default: next_ms = eeprom_link_pkg::ms_idle;
      endcase
    end
  end

  // sda is read back through two flops before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {sda_m, sda_s} <= 2'h3;
      qcnt <= '0;
    end else begin
      {sda_m, sda_s} <= {bus.sda, sda_m};
      qcnt <= tick ? '0 : qcnt + QW'(1);
    end
  end

  // registered state and outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mstate <= eeprom_link_pkg::ms_idle;
      seq <= eeprom_link_pkg::sq_dev;
      op <= eeprom_link_pkg::op_write;
      q <= 2'h0;
      bit_idx <= 4'h0;
      {tx, rx, remain} <= 24'h000000;
      addr <= 11'h000;
      {got, nack, wr_take, rd_valid, done} <= 5'h00;
      bus.scl <= 1'b1;
      bus.sda_mst_oe <= 1'b0;
      bus.sda_mst_o <= 1'b0;
      cmd_ready <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      mstate <= next_ms;
      seq <= next_seq;
      op <= next_op;
      q <= next_q;
      bit_idx <= next_bit;
      {tx, rx, remain} <= {next_tx, next_rx, next_remain};
      addr <= next_addr;
      {got, nack, wr_take, rd_valid, done} <= {next_got, next_nack, next_take, next_valid, next_done};
      bus.scl <= next_scl;
      bus.sda_mst_oe <= next_oe;
      bus.sda_mst_o <= 1'b0;
      cmd_ready <= (next_ms == eeprom_link_pkg::ms_idle);
      rd_data <= next_valid ? next_rx : rd_data;
    end
  end
endmodule // eeprom_master

/* tb/eeprom_link_monitor.sv */
// checker for the two-wire link joining the memory end and the master end
// assumes plain copies of the interface signals and one system clock domain
`timescale 1ns/10ps
`include "eeprom_link_map.svh"
module eeprom_link_monitor #(
  parameter int TWR_CYCLES = `EE_TWR_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic scl, // serial clock
  input wire logic sda, // resolved data line
  input wire logic sda_dev_o, // memory end data
  input wire logic sda_dev_oe, // memory end pulls low
  input wire logic sda_mst_oe, // master end pulls low
  input wire logic standby, // memory idle state
  input wire logic write_busy // internal write running
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  int busy_cnt;
  // length of the running internal write; a stuck timer shows up here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
  end
  property p_dev_pull_low;
    sda_dev_oe |-> !sda_dev_o && !sda;
  endproperty
  a_dev_pull_low: assert property (p_dev_pull_low) else $error("memory end drives sda high");
  property p_dev_scl_low;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("memory end moved sda with scl high");
  property p_dev_hold;
    $rose(sda_dev_oe) |=> sda_dev_oe [*8];
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("memory end released sda too early");
  property p_excl;
    scl && sda_dev_oe |-> !sda_mst_oe;
  endproperty
  a_excl: assert property (p_excl) else $error("both ends drive sda with scl high");
  property p_busy_quiet;
    write_busy |-> !sda_dev_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("memory end answered while busy");
  property p_stop_idle;
    scl && $past(scl) && $rose(sda) |-> ##[1:6] standby;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not bring standby");
  property p_start_wake;
    scl && $past(scl) && $fell(sda) |-> ##[1:6] !standby;
  endproperty
  a_start_wake: assert property (p_start_wake) else $error("start did not leave standby");
  property p_busy_after_stop;
    $rose(write_busy) |-> ##[0:3] standby;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("write began without stop");
  property p_busy_bound;
    busy_cnt <= TWR_CYCLES + 1;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("internal write ran too long");
endmodule // eeprom_link_monitor

/* tb/tb.sv */
// bench: memory end and master end joined on one link, a second pair with foreign identifier
// assumes the design files and eeprom_link_map.svh are on the include path
`timescale 1ns/10ps
`include "eeprom_link_map.svh"
module tb;
  localparam int TWR = 200;
  localparam int LIMIT = 40000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_valid2 = 1'b0;
  eeprom_link_pkg::op_t cmd_op = eeprom_link_pkg::op_write;
  logic [10:0] cmd_addr = 11'h000;
  logic [7:0] cmd_count = 8'h01;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, cmd_ready2, wr_take, rd_valid, done, done2, nack, nack2;
  logic standby, write_busy, write_busy2;
  logic [7:0] rd_data;
  logic [7:0] wbuf [16];
  logic [7:0] rdq [$];
  logic [8:0] frame;
  logic dev2_drove = 1'b0;
  int nbits, ntake, cycles, failures, checked;
  two_wire_if link ();
  two_wire_if link2 ();
  eeprom_slave #(.TWR_CYCLES(TWR)) eeprom_slave_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(link.device),
    .standby(standby), .write_busy(write_busy));
  eeprom_master #(.QTR(4)) eeprom_master_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(link.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack));
  eeprom_slave #(.TWR_CYCLES(TWR)) eeprom_slave_inst2 (.clk_sys(clk_sys), .reset_n(reset_n), .bus(link2.device),
    .standby(), .write_busy(write_busy2));
  eeprom_master #(.QTR(4), .TYPE_ID(4'hc)) eeprom_master_inst2 (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus(link2.master), .cmd_valid(cmd_valid2), .cmd_ready(cmd_ready2), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_count(cmd_count), .wr_data(wr_data), .wr_take(), .rd_data(), .rd_valid(), .done(done2), .nack(nack2));
  eeprom_link_monitor #(.TWR_CYCLES(TWR)) eeprom_link_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .scl(link.scl), .sda(link.sda), .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
    .sda_mst_oe(link.sda_mst_oe), .standby(standby), .write_busy(write_busy));
  // clock and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end
  // write bytes advance per take; read bytes are queued as they arrive
  always @(negedge clk_sys) begin
    if (wr_take === 1'b1) begin
      ntake++;
    end
    wr_data = wbuf[ntake[3:0]];
    if (rd_valid === 1'b1) begin
      rdq.push_back(rd_data);
    end
  end
  // first nine wire bits after each start, sampled as the memory end would
  always @(negedge link.sda) begin
    if (link.scl === 1'b1) begin
      nbits = 0;
    end
  end
  always @(posedge link.scl) begin
    if (nbits < 9) begin
      frame = {frame[7:0], link.sda};
      nbits++;
    end
  end
  always @(posedge link2.sda_dev_oe) begin
    dev2_drove = 1'b1;
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one whole command on pair sel; valid drops right after it is taken
  task automatic run_cmd(input logic sel, input eeprom_link_pkg::op_t op, input logic [10:0] addr,
                         input logic [7:0] cnt);
    int i;
    @(posedge clk_sys);
    ntake = 0;
    rdq.delete();
    @(negedge clk_sys);
    cmd_op = op;
    cmd_addr = addr;
    cmd_count = cnt;
    cmd_valid = !sel;
    cmd_valid2 = sel;
    i = 0;
    while ((sel ? cmd_ready2 : cmd_ready) !== 1'b1 && i < 50) begin
      @(negedge clk_sys);
      i++;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_valid2 = 1'b0;
    i = 0;
    while ((sel ? done2 : done) !== 1'b1 && i < 8000) begin
      @(negedge clk_sys);
      i++;
    end
    check_bit(i < 8000, 1'b1);
  endtask
  task automatic poll_ready();
    int n;
    n = 0;
    while (n < 20 && !(n > 0 && nack === 1'b0)) begin
      run_cmd(1'b0, eeprom_link_pkg::op_poll, 11'h000, 8'h01);
      n++;
    end
    check_bit(nack, 1'b0);
    check_bit(write_busy, 1'b0);
  endtask
  // sixteen bytes from mid-page wrap inside the page; a write during busy is refused
  task automatic t_page_write();
    for (int i = 0; i < 16; i++) begin
      wbuf[i] = 8'hc0 + 8'(i);
    end
    run_cmd(1'b0, eeprom_link_pkg::op_write, 11'h33c, 8'h10);
    check_val(16'(ntake), 16'h0010);
    check_bit(nack, 1'b0);
    check_val({7'h00, frame}, {7'h00, 4'(`EE_TYPE_ID), 3'h3, 1'b0, 1'b0});
    check_bit(link.scl & link.sda, 1'b1);
    repeat (4) @(negedge clk_sys);
    check_bit(write_busy, 1'b1);
    wbuf[0] = 8'h00;
    run_cmd(1'b0, eeprom_link_pkg::op_write, 11'h330, 8'h01);
    check_bit(nack, 1'b1);
    poll_ready();
  endtask
  task automatic t_rand_read();
    run_cmd(1'b0, eeprom_link_pkg::op_read_rand, 11'h330, 8'h10);
    check_val(16'(rdq.size()), 16'h0010);
    for (int i = 0; i < 16; i++) begin
      check_val({8'h00, rdq[i]}, {8'h00, (i < 12) ? 8'hc4 + 8'(i) : 8'hb4 + 8'(i)});
    end
    check_bit(nack, 1'b0);
    check_bit(standby, 1'b1);
  endtask
  // last and first address: counter follows accesses and wraps to zero
  task automatic t_wrap_read();
    wbuf[0] = 8'h3e;
    run_cmd(1'b0, eeprom_link_pkg::op_write, 11'h7ff, 8'h01);
    run_cmd(1'b0, eeprom_link_pkg::op_poll, 11'h000, 8'h01);
    check_bit(nack, 1'b1);
    poll_ready();
    wbuf[0] = 8'hd1;
    run_cmd(1'b0, eeprom_link_pkg::op_write, 11'h000, 8'h01);
    poll_ready();
    run_cmd(1'b0, eeprom_link_pkg::op_read_rand, 11'h7ff, 8'h01);
    check_val({8'h00, rdq[0]}, 16'h003e);
    run_cmd(1'b0, eeprom_link_pkg::op_read_cur, 11'h000, 8'h01);
    check_val({8'h00, rdq[0]}, 16'h00d1);
    run_cmd(1'b0, eeprom_link_pkg::op_read_rand, 11'h7ff, 8'h02);
    check_val({rdq[0], rdq[1]}, 16'h3ed1);
  endtask
  // foreign identifier on the second pair: no acknowledge, no write
  task automatic t_foreign();
    wbuf[0] = 8'h77;
    run_cmd(1'b1, eeprom_link_pkg::op_write, 11'h012, 8'h01);
    check_bit(nack2, 1'b1);
    check_bit(dev2_drove, 1'b0);
    check_bit(write_busy2, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_page_write();
    t_rand_read();
    t_wrap_read();
    t_foreign();
    report_and_stop();
  end
endmodule // tb
